/* rtl/mcc_cfg.svh */
// Register offsets, field positions and reset values of the capture counter
`ifndef MCC_CFG_SVH
`define MCC_CFG_SVH

`define MCC_NUM_CH 6
`define MCC_CNT_W 16
`define MCC_PRES_W 12
`define MCC_CTRL_W 18
`define MCC_STAT_W 4

// Register index inside one channel window of 32 bytes
`define MCC_OFF_CTRL 3'h0
`define MCC_OFF_CNT 3'h1
`define MCC_OFF_GRA 3'h2
`define MCC_OFF_GRB 3'h3
`define MCC_OFF_GRC 3'h4
`define MCC_OFF_GRD 3'h5
`define MCC_OFF_STAT 3'h6
`define MCC_OFF_MASK 3'h7

// Control register fields
`define MCC_F_CLK 2:0
`define MCC_F_CLR 4:3
`define MCC_F_SYNC 5
`define MCC_F_EDGA 7:6
`define MCC_F_EDGB 9:8
`define MCC_F_CAPA 10
`define MCC_F_CAPB 11
`define MCC_F_BUFA 12
`define MCC_F_BUFB 13
`define MCC_F_PH 16:14
`define MCC_F_RUN 17
`define MCC_CLK_CASCADE 3'h7

// Status and mask bit positions
`define MCC_ST_A 0
`define MCC_ST_B 1
`define MCC_ST_OVF 2
`define MCC_ST_UDF 3

`define MCC_CTRL_RST 18'h00000
`define MCC_GR_RST 16'hFFFF

`endif

/* rtl/mcc_pkg.sv */
// Types shared by the capture counter modules
package mcc_pkg;
  typedef enum logic [1:0] {
    MCC_CLR_NONE = 2'b00,
    MCC_CLR_A = 2'b01,
    MCC_CLR_B = 2'b10,
    MCC_CLR_SYNC = 2'b11
  } mcc_clr_t;

  typedef enum logic [1:0] {
    MCC_EDGE_RISE = 2'b00,
    MCC_EDGE_FALL = 2'b01,
    MCC_EDGE_BOTH = 2'b10,
    MCC_EDGE_BOTH2 = 2'b11
  } mcc_edge_t;

  typedef enum logic [2:0] {
    MCC_PH_OFF = 3'b000,
    MCC_PH_M1 = 3'b001,
    MCC_PH_M2 = 3'b010,
    MCC_PH_M3 = 3'b011,
    MCC_PH_M4 = 3'b100
  } mcc_phase_t;
endpackage

/* rtl/mcc_pin_sync.sv */
// Two-stage synchroniser with edge detection for the timer pins
`timescale 1ns/1ps
module mcc_pin_sync #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_lvl,
  output logic [W-1:0] o_prev,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] prev_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      lvl_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= i_pin;
      lvl_r <= meta_r;
      prev_r <= lvl_r;
    end
  end

  // Edges seen on the settled copies only
  assign o_lvl = lvl_r;
  assign o_prev = prev_r;
  assign o_rise = lvl_r & ~prev_r;
  assign o_fall = ~lvl_r & prev_r;
endmodule

/* rtl/mcc_phase_dec.sv */
// Two-phase encoder decoder for the four phase counting modes
`timescale 1ns/1ps
module mcc_phase_dec
  import mcc_pkg::*;
(
  input wire logic i_a,
  input wire logic i_b,
  input wire logic i_a_prev,
  input wire logic i_b_prev,
  input wire mcc_phase_t i_mode,
  output logic o_up,
  output logic o_dn
);
  logic a_r;
  logic a_f;
  logic b_r;
  logic b_f;

  assign a_r = i_a & ~i_a_prev;
  assign a_f = ~i_a & i_a_prev;
  assign b_r = i_b & ~i_b_prev;
  assign b_f = ~i_b & i_b_prev;

  // Count conditions per mode; both pins moving at once is ignored in mode 1 only
  always_comb begin
    o_up = 1'b0;
    o_dn = 1'b0;
    case (i_mode)
      MCC_PH_M1: begin
        o_up = (i_a & b_r) | (~i_a & b_f) | (a_r & ~i_b) | (a_f & i_b);
        o_dn = (i_a & b_f) | (~i_a & b_r) | (a_r & i_b) | (a_f & ~i_b);
      end
      MCC_PH_M2: begin
        // Only pin a falling counts; pin b level gives the direction
        o_up = a_f & i_b;
        o_dn = a_f & ~i_b;
      end
      MCC_PH_M3: begin
        o_up = a_f & i_b;
        o_dn = i_a & b_f;
      end
      MCC_PH_M4: begin
        o_up = (i_a & b_r) | (~i_a & b_f);
        o_dn = (i_a & b_f) | (~i_a & b_r);
      end
      default: begin
        o_up = 1'b0;
        o_dn = 1'b0;
      end
    endcase
  end
endmodule

/* rtl/mcc_timer.sv */
// Six-channel 16-bit capture counter with APB registers
// Notes on behaviour
// - A selected edge on a channel capture pin copies the counter into its capture register.
// - Each capture pin edge is selectable as rising, falling or both.
// - A capture can be chosen to clear the channel counter to zero.
// - Phase counting makes the counter go up or down from two encoder inputs.
// - Four phase counting modes exist, only on channels 1, 2, 4 and 5.
// - Channels 1 and 5 use encoder pins a/b, channels 2 and 4 use pins c/d.
// - Only channels 0 and 3 buffer, the third and fourth registers serving the first two.
// - With buffered compare, a match reloads the register from its buffer; only an A match also toggles the pin.
// - With buffered capture, the old register content moves into the buffer.
// - Cascading joins two 16-bit counters into one 32-bit counter.
// - Cascading is allowed only for pairs 1/2 and 4/5.
// - The upper counter steps up on lower overflow and down on lower underflow.
// - Simultaneous captures on a cascaded pair split the 32-bit value upper/lower.
// - A counter write on a synchronized channel writes every synchronized counter.
// - Any clear in a synchronized channel clears all synchronized counters together.
// - Each channel sets separate flags for captures/matches, overflow and underflow; all of them share the one o_irq line.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "mcc_cfg.svh"
module mcc_timer
  import mcc_pkg::*;
#(
  parameter int CNT_W = `MCC_CNT_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [5:0] i_first_capture_pin,
  input wire logic [5:0] i_second_capture_pin,
  input wire logic i_ext_clock_in_a,
  input wire logic i_ext_clock_in_b,
  input wire logic i_ext_clock_in_c,
  input wire logic i_ext_clock_in_d,
  output logic [5:0] o_compare_out,
  output logic o_irq
);
  localparam int NCH = `MCC_NUM_CH;

  // Channel capability helpers
  function automatic logic phase_capable(input int c);
    return (c == 1) || (c == 2) || (c == 4) || (c == 5);
  endfunction

  function automatic logic buf_capable(input int c);
    return (c == 0) || (c == 3);
  endfunction

  function automatic logic casc_upper(input int c);
    return (c == 1) || (c == 4);
  endfunction

  // Prescaler tap decode: 1, 4, 16, 64, 256, 1024, 4096
  function automatic logic pres_tick(input logic [2:0] sel, input logic [11:0] p);
    case (sel)
      3'h0: return 1'b1;
      3'h1: return &p[1:0];
      3'h2: return &p[3:0];
      3'h3: return &p[5:0];
      3'h4: return &p[7:0];
      3'h5: return &p[9:0];
      3'h6: return &p[11:0];
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic edge_hit(input mcc_edge_t sel, input logic r, input logic f);
    case (sel)
      MCC_EDGE_RISE: return r;
      MCC_EDGE_FALL: return f;
      default: return r | f;
    endcase
  endfunction

  // Drop settings a channel cannot have
  function automatic logic [17:0] ctrl_clean(input int c, input logic [17:0] v);
    logic [17:0] o;
    o = v;
    if (!phase_capable(c)) begin
      o[`MCC_F_PH] = 3'h0;
    end else if (v[`MCC_F_PH] > 3'h4) begin
      o[`MCC_F_PH] = 3'h0;
    end
    if (!buf_capable(c)) begin
      o[`MCC_F_BUFA] = 1'b0;
      o[`MCC_F_BUFB] = 1'b0;
    end
    // cascade select only on upper channels
    if (!casc_upper(c) && v[`MCC_F_CLK] == `MCC_CLK_CASCADE) begin
      o[`MCC_F_CLK] = 3'h0;
    end
    return o;
  endfunction

  logic [11:0] pres_r;
  logic [NCH-1:0][17:0] ctrl_r;
  logic [NCH-1:0][CNT_W-1:0] cnt_r;
  logic [NCH-1:0][CNT_W-1:0] gra_r;
  logic [NCH-1:0][CNT_W-1:0] grb_r;
  logic [NCH-1:0][CNT_W-1:0] grc_r;
  logic [NCH-1:0][CNT_W-1:0] grd_r;
  logic [NCH-1:0][3:0] stat_r;
  logic [NCH-1:0][3:0] mask_r;
  logic [NCH-1:0] eqa_r;
  logic [NCH-1:0] eqb_r;
  logic [NCH-1:0] cmp_out_r;
  logic [31:0] rdata_r;

  logic [15:0] pin_lvl;
  logic [15:0] pin_prev;
  logic [15:0] pin_rise;
  logic [15:0] pin_fall;
  logic [NCH-1:0] ph_up;
  logic [NCH-1:0] ph_dn;
  logic [NCH-1:0] up_s;
  logic [NCH-1:0] dn_s;
  logic [NCH-1:0] ovf_s;
  logic [NCH-1:0] udf_s;
  logic [NCH-1:0] cap_a_s;
  logic [NCH-1:0] cap_b_s;
  logic [NCH-1:0] mat_a_s;
  logic [NCH-1:0] mat_b_s;
  logic [NCH-1:0] clr_own_s;
  logic [NCH-1:0] clr_s;
  logic [NCH-1:0] cnt_wr_s;
  logic [NCH-1:0] sync_en;

  logic [2:0] a_ch;
  logic [2:0] a_reg;
  logic a_ok;
  logic wr_en;
  logic [31:0] rd_nxt;

  // Pins: first capture [5:0], second capture [11:6], encoder a..d [15:12]
  mcc_pin_sync #(
    .W(16)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin({i_ext_clock_in_d, i_ext_clock_in_c, i_ext_clock_in_b, i_ext_clock_in_a,
            i_second_capture_pin, i_first_capture_pin}),
    .o_lvl(pin_lvl),
    .o_prev(pin_prev),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // One decoder per channel; channels without the mode see it forced off
  for (genvar g = 0; g < NCH; g++) begin : g_ph
    localparam int PA = ((g == 2) || (g == 4)) ? 14 : 12;
    mcc_phase_dec u_dec (
      .i_a(pin_lvl[PA]),
      .i_b(pin_lvl[PA+1]),
      .i_a_prev(pin_prev[PA]),
      .i_b_prev(pin_prev[PA+1]),
      .i_mode(mcc_phase_t'(ctrl_r[g][`MCC_F_PH])),
      .o_up(ph_up[g]),
      .o_dn(ph_dn[g])
    );
  end

  // APB decode: 32-byte window per channel, word aligned
  assign a_ch = i_paddr[7:5];
  assign a_reg = i_paddr[4:2];
  assign a_ok = (a_ch < 3'(NCH)) && (i_paddr[1:0] == 2'b00);
  assign wr_en = i_psel & i_penable & i_pwrite & a_ok;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~a_ok;

  // Counting, capture, match and clear decisions per channel
  always_comb begin
    up_s = '0;
    dn_s = '0;
    ovf_s = '0;
    udf_s = '0;
    cap_a_s = '0;
    cap_b_s = '0;
    mat_a_s = '0;
    mat_b_s = '0;
    clr_own_s = '0;
    // Walk downward so the lower cascade half is settled first
    for (int c = NCH - 1; c >= 0; c--) begin
      if (ctrl_r[c][`MCC_F_PH] != 3'h0) begin
        up_s[c] = ph_up[c];
        dn_s[c] = ph_dn[c];
      end else if (ctrl_r[c][`MCC_F_CLK] == `MCC_CLK_CASCADE) begin
        // upper half steps from the lower half
        up_s[c] = ovf_s[3'((c + 1) % NCH)];
        dn_s[c] = udf_s[3'((c + 1) % NCH)];
      end else begin
        up_s[c] = ctrl_r[c][`MCC_F_RUN] & pres_tick(ctrl_r[c][`MCC_F_CLK], pres_r);
      end
      ovf_s[c] = up_s[c] & (&cnt_r[c]);
      udf_s[c] = dn_s[c] & ~up_s[c] & (cnt_r[c] == '0);
      // capture on the selected pin edge
      cap_a_s[c] = ctrl_r[c][`MCC_F_CAPA] &
        edge_hit(mcc_edge_t'(ctrl_r[c][`MCC_F_EDGA]), pin_rise[c], pin_fall[c]);
      cap_b_s[c] = ctrl_r[c][`MCC_F_CAPB] &
        edge_hit(mcc_edge_t'(ctrl_r[c][`MCC_F_EDGB]), pin_rise[c+6], pin_fall[c+6]);
      // Match fires once as the counter arrives at the value
      mat_a_s[c] = ~ctrl_r[c][`MCC_F_CAPA] & (cnt_r[c] == gra_r[c]) & ~eqa_r[c];
      mat_b_s[c] = ~ctrl_r[c][`MCC_F_CAPB] & (cnt_r[c] == grb_r[c]) & ~eqb_r[c];
      // capture or match as clearing source
      case (mcc_clr_t'(ctrl_r[c][`MCC_F_CLR]))
        MCC_CLR_A: clr_own_s[c] = cap_a_s[c] | mat_a_s[c];
        MCC_CLR_B: clr_own_s[c] = cap_b_s[c] | mat_b_s[c];
        default: clr_own_s[c] = 1'b0;
      endcase
    end
  end

  // Synchronized group: shared clear and shared counter write
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      sync_en[c] = ctrl_r[c][`MCC_F_SYNC];
    end
    // one clear in the group clears all of it
    clr_s = clr_own_s | (sync_en & {NCH{|(clr_own_s & sync_en)}});
    cnt_wr_s = '0;
    if (wr_en && a_reg == `MCC_OFF_CNT) begin
      cnt_wr_s[a_ch] = 1'b1;
      if (sync_en[a_ch]) begin
        cnt_wr_s = cnt_wr_s | sync_en;
      end
    end
  end

  // Free-running prescaler shared by all channels
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pres_r <= '0;
    end else begin
      pres_r <= pres_r + 12'h001;
    end
  end

  // Control and mask registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= '0;
      mask_r <= '0;
    end else if (wr_en) begin
      if (a_reg == `MCC_OFF_CTRL) begin
        ctrl_r[a_ch] <= ctrl_clean(int'(a_ch), i_pwdata[17:0]);
      end else if (a_reg == `MCC_OFF_MASK) begin
        mask_r[a_ch] <= i_pwdata[3:0];
      end
    end
  end

  // Counters: clear beats write, write beats counting
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (clr_s[c]) begin
          cnt_r[c] <= '0;
        end else if (cnt_wr_s[c]) begin
          cnt_r[c] <= i_pwdata[CNT_W-1:0];
        end else if (up_s[c] && !dn_s[c]) begin
          cnt_r[c] <= cnt_r[c] + 1'b1;
        end else if (dn_s[c] && !up_s[c]) begin
          cnt_r[c] <= cnt_r[c] - 1'b1;
        end
      end
    end
  end

  // First register and its buffer; hardware events beat software writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gra_r <= {NCH{`MCC_GR_RST}};
      grc_r <= {NCH{`MCC_GR_RST}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (cap_a_s[c]) begin
          // both cascade halves sample the same cycle
          gra_r[c] <= cnt_r[c];
        end else if (ctrl_r[c][`MCC_F_BUFA] && mat_a_s[c]) begin
          gra_r[c] <= grc_r[c];
        end else if (wr_en && a_ch == 3'(c) && a_reg == `MCC_OFF_GRA) begin
          gra_r[c] <= i_pwdata[CNT_W-1:0];
        end
        if (ctrl_r[c][`MCC_F_BUFA] && cap_a_s[c]) begin
          grc_r[c] <= gra_r[c];
        end else if (wr_en && a_ch == 3'(c) && a_reg == `MCC_OFF_GRC) begin
          grc_r[c] <= i_pwdata[CNT_W-1:0];
        end
      end
    end
  end

  // Second register and its buffer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grb_r <= {NCH{`MCC_GR_RST}};
      grd_r <= {NCH{`MCC_GR_RST}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (cap_b_s[c]) begin
          grb_r[c] <= cnt_r[c];
        end else if (ctrl_r[c][`MCC_F_BUFB] && mat_b_s[c]) begin
          grb_r[c] <= grd_r[c];
        end else if (wr_en && a_ch == 3'(c) && a_reg == `MCC_OFF_GRB) begin
          grb_r[c] <= i_pwdata[CNT_W-1:0];
        end
        if (ctrl_r[c][`MCC_F_BUFB] && cap_b_s[c]) begin
          grd_r[c] <= grb_r[c];
        end else if (wr_en && a_ch == 3'(c) && a_reg == `MCC_OFF_GRD) begin
          grd_r[c] <= i_pwdata[CNT_W-1:0];
        end
      end
    end
  end

  // Match history; reset high so a zero counter is not a false match
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eqa_r <= '1;
      eqb_r <= '1;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        eqa_r[c] <= cnt_r[c] == gra_r[c];
        eqb_r[c] <= cnt_r[c] == grb_r[c];
      end
    end
  end

  // Compare output toggles on the first match of A, same edge as any A reload
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_out_r <= '0;
    end else begin
      cmp_out_r <= cmp_out_r ^ mat_a_s;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_r <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        logic [3:0] clr_m;
        logic [3:0] set_m;
        clr_m = (wr_en && a_ch == 3'(c) && a_reg == `MCC_OFF_STAT) ? i_pwdata[3:0] : 4'h0;
        set_m = {udf_s[c], ovf_s[c], cap_b_s[c] | mat_b_s[c], cap_a_s[c] | mat_a_s[c]};
        stat_r[c] <= (stat_r[c] & ~clr_m) | set_m;
      end
    end
  end

  // Read mux, sampled in the setup cycle
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (a_ok) begin
      if (a_reg == `MCC_OFF_CTRL) begin
        rd_nxt = {14'h0000, ctrl_r[a_ch]};
      end else if (a_reg == `MCC_OFF_CNT) begin
        rd_nxt = {16'h0000, cnt_r[a_ch]};
      end else if (a_reg == `MCC_OFF_GRA) begin
        rd_nxt = {16'h0000, gra_r[a_ch]};
      end else if (a_reg == `MCC_OFF_GRB) begin
        rd_nxt = {16'h0000, grb_r[a_ch]};
      end else if (a_reg == `MCC_OFF_GRC) begin
        rd_nxt = {16'h0000, grc_r[a_ch]};
      end else if (a_reg == `MCC_OFF_GRD) begin
        rd_nxt = {16'h0000, grd_r[a_ch]};
      end else if (a_reg == `MCC_OFF_STAT) begin
        rd_nxt = {28'h0000000, stat_r[a_ch]};
      end else begin
        rd_nxt = {28'h0000000, mask_r[a_ch]};
      end
    end
  end

  // Read data held through the access phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= '0;
    end else if (i_psel && !i_penable) begin
      rdata_r <= rd_nxt;
    end
  end

  // Interrupt and output pins
  always_comb begin
    o_irq = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      o_irq = o_irq | (|(stat_r[c] & mask_r[c]));
    end
  end

  assign o_prdata = rdata_r;
  assign o_compare_out = cmp_out_r;
endmodule

/* sim/mcc_enc_model.sv */
// Encoder and capture pin driver standing outside the timer
`timescale 1ns/1ps
module mcc_enc_model (
  input wire logic i_clk,
  output logic [3:0] o_enc = 4'h0,
  output logic [5:0] o_cap_a = 6'h00,
  output logic [5:0] o_cap_b = 6'h00
);
  // quadrature steps, one pin moves per step so none is refused
  task automatic step(input bit cd, input bit fwd, input int n);
    logic [1:0] p;
    for (int i = 0; i < n; i++) begin
      p = cd ? o_enc[3:2] : o_enc[1:0];
      // Forward lets pin a lead pin b
      p = fwd ? {p[0], ~p[1]} : {~p[0], p[1]};
      @(posedge i_clk);
      if (cd) begin
        o_enc[3:2] <= p;
      end else begin
        o_enc[1:0] <= p;
      end
      // Held four clocks, above the two-clock minimum
      repeat (3) @(posedge i_clk);
    end
  endtask
  // Capture pin level change, held long enough to be synchronised
  task automatic cap(input logic [5:0] m, input logic lv);
    @(posedge i_clk);
    o_cap_a <= lv ? (o_cap_a | m) : (o_cap_a & ~m);
    repeat (5) @(posedge i_clk);
  endtask
  // Second capture pin level change, same timing
  task automatic capb(input logic [5:0] m, input logic lv);
    @(posedge i_clk);
    o_cap_b <= lv ? (o_cap_b | m) : (o_cap_b & ~m);
    repeat (5) @(posedge i_clk);
  endtask
endmodule

/* sim/mcc_timer_chk.sv */
// Port checker for the capture counter, bound to its top module
`timescale 1ns/1ps
module mcc_timer_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [5:0] o_compare_out,
  input wire logic o_irq
);
  logic acc;
  logic bad;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Access phase and unmapped decode
  assign acc = i_psel & i_penable;
  assign bad = (i_paddr[7:5] > 3'h5) | (i_paddr[1:0] != 2'h0);
  chk_ready_high: assert property (o_pready) else $error("pready low");
  chk_err_unmapped: assert property (acc && bad |-> o_pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc && !bad |-> !o_pslverr)
    else $error("error on mapped access");
  chk_err_idle: assert property (!acc |-> !o_pslverr) else $error("error outside access");
  chk_err_pulse: assert property (o_pslverr |=> !o_pslverr) else $error("error held");
  // Read data only moves at a setup edge
  chk_rdata_hold: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
    else $error("read data moved");
  chk_rdata_zero: assert property (i_psel && !i_penable && !i_pwrite && bad |=>
    o_prdata == 32'h0) else $error("unmapped read not zero");
  chk_irq_reset: assert property ($rose(i_rst_n) |-> !o_irq)
    else $error("irq after reset");
  chk_cmp_reset: assert property ($rose(i_rst_n) |-> o_compare_out == 6'h00)
    else $error("compare out after reset");
  cover property (acc && bad);
  cover property ($rose(o_irq));
  cover property ($changed(o_compare_out));
endmodule
bind mcc_timer mcc_timer_chk mcc_timer_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_compare_out(o_compare_out), .o_irq(o_irq));

/* sim/tb.sv */
// Self-checking bench for the six-channel capture counter
`timescale 1ns/1ps
`include "mcc_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic [31:0] rd;
  logic o_pready;
  logic o_pslverr;
  logic o_irq;
  logic [3:0] enc;
  logic [5:0] cap_a;
  logic [5:0] cap_b;
  logic [5:0] o_compare_out;
  logic [31:0] ph_exp [1:4] = '{32'h8, 32'h2, 32'h2, 32'h4};
  int errors = 0;
  int compares = 0;
  // Free-running system clock
  always #4 i_clk = ~i_clk;
  mcc_timer #(.CNT_W(16)) mcc_timer_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_first_capture_pin(cap_a), .i_second_capture_pin(cap_b),
    .i_ext_clock_in_a(enc[0]), .i_ext_clock_in_b(enc[1]), .i_ext_clock_in_c(enc[2]),
    .i_ext_clock_in_d(enc[3]), .o_compare_out(o_compare_out), .o_irq(o_irq));
  mcc_enc_model mcc_enc_model_i (.i_clk(i_clk), .o_enc(enc), .o_cap_a(cap_a),
    .o_cap_b(cap_b));
  function automatic logic [7:0] ad(input int ch, input logic [2:0] off);
    return {ch[2:0], off, 2'b00};
  endfunction
  // One APB transfer; waits for pready, samples read data at that edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge i_clk);
    end
    if (n >= 50) begin
      errors++;
      $display("MISMATCH %0t pready never came", $time);
    end
    rd = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input int ch, input logic [2:0] off, input logic [31:0] d);
    xfer(ad(ch, off), 1'b1, d);
  endtask
  task automatic rdc(input int ch, input logic [2:0] off, input logic [31:0] e);
    xfer(ad(ch, off), 1'b0, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    tick(40000);
    errors++;
    summarize();
  end
  initial begin
    tick(8);
    i_rst_n <= 1'b1;
    // Reset values, then an unmapped channel
    for (int c = 0; c < 6; c++) begin
      rdc(c, `MCC_OFF_GRA, 32'hFFFF);
      rdc(c, `MCC_OFF_STAT, 32'h0);
    end
    rdc(6, `MCC_OFF_CTRL, 32'h0);
    // Edge selection with capture clearing the stopped counter
    wr(0, `MCC_OFF_MASK, 32'h1);
    for (int e = 0; e < 3; e++) begin
      wr(0, `MCC_OFF_GRA, 32'h0);
      wr(0, `MCC_OFF_CTRL, 32'h408 | (e << 6));
      wr(0, `MCC_OFF_CNT, 32'h1100 + e);
      mcc_enc_model_i.cap(6'h01, 1'b1);
      rdc(0, `MCC_OFF_GRA, e == 1 ? 32'h0 : 32'h1100 + e);
      wr(0, `MCC_OFF_CNT, 32'h2200 + e);
      mcc_enc_model_i.cap(6'h01, 1'b0);
      rdc(0, `MCC_OFF_GRA, e == 0 ? 32'h1100 : 32'h2200 + e);
      rdc(0, `MCC_OFF_CNT, e == 0 ? 32'h2200 : 32'h0);
    end
    // Interrupt raised, cleared, then masked
    `CHK(o_irq, 1'b1)
    wr(0, `MCC_OFF_STAT, 32'hF);
    tick(2);
    `CHK(o_irq, 1'b0)
    wr(0, `MCC_OFF_MASK, 32'h0);
    mcc_enc_model_i.cap(6'h01, 1'b1);
    rdc(0, `MCC_OFF_STAT, 32'h1);
    `CHK(o_irq, 1'b0)
    mcc_enc_model_i.cap(6'h01, 1'b0);
    // Buffered capture on channel 0, none on channel 1
    for (int c = 0; c < 2; c++) begin
      wr(c, `MCC_OFF_CTRL, 32'h1400);
      wr(c, `MCC_OFF_GRA, 32'hAAAA);
      wr(c, `MCC_OFF_CNT, 32'h1111);
    end
    mcc_enc_model_i.cap(6'h03, 1'b1);
    rdc(0, `MCC_OFF_GRA, 32'h1111);
    rdc(0, `MCC_OFF_GRC, 32'hAAAA);
    rdc(1, `MCC_OFF_GRC, 32'hFFFF);
    mcc_enc_model_i.cap(6'h03, 1'b0);
    // Buffered compare on channel 3: one match near count 16
    wr(3, `MCC_OFF_GRA, 32'h10);
    wr(3, `MCC_OFF_GRC, 32'h20);
    wr(3, `MCC_OFF_CNT, 32'h0);
    wr(3, `MCC_OFF_CTRL, 32'h21000);
    tick(20);
    wr(3, `MCC_OFF_CTRL, 32'h1000);
    tick(2);
    `CHK(o_compare_out[3], 1'b1)
    rdc(3, `MCC_OFF_GRA, 32'h20);
    rdc(3, `MCC_OFF_STAT, 32'h1);
    // Every phase mode, encoder moving forward
    for (int m = 1; m < 5; m++) begin
      wr(1, `MCC_OFF_CTRL, m << 14);
      wr(1, `MCC_OFF_CNT, 32'h0);
      mcc_enc_model_i.step(1'b0, 1'b1, 8);
      tick(6);
      rdc(1, `MCC_OFF_CNT, ph_exp[m]);
    end
    wr(0, `MCC_OFF_CTRL, 32'h4007);
    rdc(0, `MCC_OFF_CTRL, 32'h0);
    wr(2, `MCC_OFF_CTRL, 32'h7);
    rdc(2, `MCC_OFF_CTRL, 32'h0);
    // Cascade 1 over 2 through a wrap each way, then a 32-bit capture
    wr(1, `MCC_OFF_CTRL, 32'h407);
    wr(2, `MCC_OFF_CTRL, 32'h4400);
    wr(5, `MCC_OFF_CTRL, 32'h4000);
    wr(1, `MCC_OFF_CNT, 32'h03A1);
    wr(2, `MCC_OFF_CNT, 32'hFFFE);
    wr(5, `MCC_OFF_CNT, 32'h0);
    mcc_enc_model_i.step(1'b1, 1'b1, 4);
    tick(6);
    rdc(1, `MCC_OFF_CNT, 32'h03A2);
    mcc_enc_model_i.step(1'b1, 1'b0, 4);
    tick(6);
    rdc(1, `MCC_OFF_CNT, 32'h03A1);
    rdc(2, `MCC_OFF_STAT, 32'hE);
    rdc(5, `MCC_OFF_CNT, 32'h0);
    mcc_enc_model_i.step(1'b0, 1'b1, 4);
    tick(6);
    rdc(5, `MCC_OFF_CNT, 32'h4);
    rdc(2, `MCC_OFF_CNT, 32'hFFFE);
    mcc_enc_model_i.cap(6'h06, 1'b1);
    rdc(1, `MCC_OFF_GRA, 32'h03A1);
    rdc(2, `MCC_OFF_GRA, 32'hFFFE);
    // Synchronous preset and clear across channels 0 and 3
    wr(0, `MCC_OFF_CTRL, 32'h20);
    wr(3, `MCC_OFF_CTRL, 32'h428);
    wr(4, `MCC_OFF_CNT, 32'h77);
    wr(0, `MCC_OFF_CNT, 32'h55);
    rdc(3, `MCC_OFF_CNT, 32'h55);
    rdc(4, `MCC_OFF_CNT, 32'h77);
    mcc_enc_model_i.cap(6'h08, 1'b1);
    rdc(0, `MCC_OFF_CNT, 32'h0);
    rdc(3, `MCC_OFF_GRA, 32'h55);
    rdc(4, `MCC_OFF_CNT, 32'h77);
    // Second pin: falling capture clears the counter
    wr(4, `MCC_OFF_CTRL, 32'h910);
    mcc_enc_model_i.capb(6'h10, 1'b1);
    rdc(4, `MCC_OFF_GRB, 32'hFFFF);
    mcc_enc_model_i.capb(6'h10, 1'b0);
    rdc(4, `MCC_OFF_GRB, 32'h77);
    rdc(4, `MCC_OFF_CNT, 32'h0);
    rdc(4, `MCC_OFF_STAT, 32'h2);
    summarize();
  end
endmodule
